// ==== src/bus_cycle.sv ====
`timescale 1ns/1ns
`default_nettype none
// One bus cycle on the parallel strobes: chip select and write or output
// strobe held low for a fixed number of clocks, address set up before.
module bus_cycle #(
  parameter int PULSE = flash_host_pkg::PULSE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic isWrite,
  input wire logic [19:0] addrIn,
  input wire logic [15:0] dataIn,
  input wire logic [15:0] dqIn,
  output logic busy,
  output logic done,
  output logic [15:0] rdData,
  output logic [19:0] addr,
  output logic [15:0] dqOut,
  output logic dqOe_n,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  logic [7:0] cnt_ff;
  logic [1:0] ph_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_ff <= 2'h0;
      cnt_ff <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      dqOe_n <= 1'b1;
      addr <= 20'h00000;
      dqOut <= 16'h0000;
      rdData <= 16'h0000;
    end else begin
      done <= 1'b0;
      unique case (ph_ff)
        2'h0: if (start) begin
          addr <= addrIn;
          dqOut <= dataIn;
          dqOe_n <= ~isWrite;
          busy <= 1'b1;
          oe_n <= isWrite;
          ph_ff <= 2'h1;
        end
        2'h1: begin
          // Write strobe falls with the output strobe already high.
          ce_n <= 1'b0;
          we_n <= ~oe_n;
          oe_n <= oe_n;
          cnt_ff <= 8'(PULSE);
          ph_ff <= 2'h3;
        end
        2'h3: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            rdData <= dqIn;
            we_n <= 1'b1;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            ph_ff <= 2'h2;
          end
        end
        2'h2: begin
          dqOe_n <= 1'b1;
          busy <= 1'b0;
          done <= 1'b1;
          ph_ff <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Strobe checks
  // ----------------------------------------------------------------
  // Chip select falls after the output strobe, so the device latches
  // its status on that later fall and every read sees fresh contents.
  sequence s_read_open;
    $fell(oe_n) ##1 $fell(ce_n);
  endsequence

  property p_read_open;
    @(posedge clk) disable iff (sys_rst)
      $fell(oe_n) |-> s_read_open;
  endproperty
  a_read_open: assert property (p_read_open) else $error("ce order"); // R3

  property p_load_oe;
    @(posedge clk) disable iff (sys_rst)
      (!we_n) |-> oe_n;
  endproperty
  a_load_oe: assert property (p_load_oe) else $error("oe low"); // R14

  property p_dq_write;
    @(posedge clk) disable iff (sys_rst)
      (!we_n) |-> !dqOe_n;
  endproperty
  a_dq_write: assert property (p_dq_write) else $error("no drive"); // R14

  property p_dq_read;
    @(posedge clk) disable iff (sys_rst)
      (!oe_n) |-> (dqOe_n && we_n);
  endproperty
  a_dq_read: assert property (p_dq_read) else $error("bus clash"); // R3
endmodule
`default_nettype wire

// ==== src/flash_host_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1 - Status reads continue until another command; read-array returns the array.
// R2 - Status upper byte reads zero in word mode; byte mode floats upper lines.
// R3 - Status latched on later strobe fall; host toggles strobes for each read.
// R4 - Error bits four and five clear only by clear-status.
// R5 - With error set only clear, read-status and read-array are accepted.
// R6 - Sleep ignored once erase-suspend has been issued.
// R7 - Sleep is three writes ending in the sleep code.
// R8 - Device finishes operation, sets sleep flag, stays in status mode.
// R9 - Read-array wakes the device and clears the sleep flag.
// R10 - Buffer write is two unlocks, buffer-write code, then bytes any order.
// R11 - Buffer byte address comes from low address bits at write fall.
// R12 - Next buffer byte must start within 30 us of previous rise.
// R13 - Buffer read is two unlocks and read code, ended by read/reset.
// R14 - Loads hold output strobe high; address on later fall, data on rise.
// R15 - Width select sampled on the third command write fall.
// R16 - Power-up puts the device in read-array mode.
// R17 - Lock is six writes; host waits for ready flag afterwards.
// R18 - ID read at lock offset shows lock state; status bit one too.
// R19 - Reset/power-down pin low refuses all program and erase.
// R20 - Write-protect low locks boot block only.
// R21 - Write-protect at elevated level unlocks the boot block.
// R22 - Both pins normal high: boot block follows its lock bit.
// R23 - Host checks ready flag before reading error bits.
// R24 - Host retries lock on failed check and repeats it three more times; the code repeats it three times regardless and flags a failed final check.
module flash_host_ctrl #(
  parameter int LOAD_GAP = flash_host_pkg::LOAD_GAP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reqValid,
  input wire logic [3:0] reqOp,
  input wire logic [19:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic wordMode,
  input wire logic protLow,
  input wire logic protElevated,
  input wire logic [15:0] dqIn,
  output logic reqReady,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic rspError,
  output logic [19:0] addr,
  output logic [15:0] dqOut,
  output logic dqOe_n,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic byteWide_n,
  output logic reset_powerdown_pin,
  output logic wpLow,
  output logic elevated_high_level
);
  // ----------------------------------------------------------------
  // Orders: 0 read array, 1 read status, 2 clear status, 3 sleep,
  // 4 buffer load (one byte), 5 buffer read, 6 lock, 7 read lock id,
  // 8 raw read, 9 power down, 10 power up.
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_UNL1 = 4'h1,
    ST_UNL2 = 4'h3,
    ST_CMD = 4'h2,
    ST_DATA = 4'h6,
    ST_POLL = 4'h7,
    ST_DONE = 4'h5,
    ST_REPEAT = 4'h4,
    ST_LOCK1 = 4'hc,
    ST_LOCK2 = 4'h8
  } state_t;

  state_t state_ff;
  logic [3:0] op_ff;
  logic [19:0] addr_ff;
  logic [15:0] data_ff;
  logic [7:0] cmd_ff;
  logic bufOpen_ff;
  logic [31:0] gap_ff;
  logic [2:0] lockCnt_ff;
  logic start;
  logic isWrite;
  logic [19:0] cyAddr;
  logic [15:0] cyData;
  logic cyDone;
  logic cyBusy;
  logic [15:0] cyRd;

  function automatic logic [7:0] opCode(input logic [3:0] op);
    unique case (op)
      4'h0: opCode = flash_host_pkg::CMD_READ_ARRAY;
      4'h1: opCode = flash_host_pkg::CMD_READ_STATUS;
      4'h2: opCode = flash_host_pkg::CMD_CLEAR_STATUS;
      4'h3: opCode = flash_host_pkg::CMD_SLEEP;
      4'h4: opCode = flash_host_pkg::CMD_BUF_WRITE;
      4'h5: opCode = flash_host_pkg::CMD_BUF_READ;
      4'h6: opCode = flash_host_pkg::CMD_LOCK_SETUP;
      4'h7: opCode = flash_host_pkg::CMD_READ_ID;
      default: opCode = flash_host_pkg::CMD_READ_ARRAY;
    endcase
  endfunction

  // Ops 0..7 go through the unlock prelude, except a buffer load while the buffer is still open; the rest do not.
  function automatic logic usesUnlock(input logic [3:0] op);
    usesUnlock = (op < 4'h8);
  endfunction

  bus_cycle u_cycle (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(start),
    .isWrite(isWrite),
    .addrIn(cyAddr),
    .dataIn(cyData),
    .dqIn(dqIn),
    .busy(cyBusy),
    .done(cyDone),
    .rdData(cyRd),
    .addr(addr),
    .dqOut(dqOut),
    .dqOe_n(dqOe_n),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n)
  );

  // ----------------------------------------------------------------
  // Cycle issue
  // ----------------------------------------------------------------
  always_comb begin
    start = 1'b0;
    isWrite = 1'b1;
    cyAddr = addr_ff;
    cyData = 16'h0000;
    if (!cyBusy && !cyDone) begin
      unique case (state_ff)
        ST_UNL1, ST_REPEAT: begin
          start = 1'b1;
          cyAddr = flash_host_pkg::UNLOCK_ADDR1;
          cyData = {8'h00, flash_host_pkg::UNLOCK_DATA1};
        end
        ST_UNL2, ST_LOCK1: begin
          start = 1'b1;
          cyAddr = flash_host_pkg::UNLOCK_ADDR2;
          cyData = {8'h00, flash_host_pkg::UNLOCK_DATA2};
        end
        ST_CMD: begin
          // Third cycle: the width select is already steady here. R15
          start = 1'b1;
          cyAddr = flash_host_pkg::UNLOCK_ADDR1;
          cyData = {8'h00, cmd_ff};
        end
        ST_LOCK2: begin
          start = 1'b1;
          cyAddr = flash_host_pkg::UNLOCK_ADDR1;
          cyData = {8'h00, flash_host_pkg::CMD_LOCK};
        end
        ST_DATA: begin
          start = 1'b1;
          // Loads keep the output strobe high. R14
          isWrite = (op_ff == 4'h4);
          cyAddr = addr_ff; // R13
          cyData = data_ff;
        end
        ST_POLL: begin
          // A fresh strobe pulse per poll relatches the status. R3
          start = 1'b1;
          isWrite = 1'b0;
        end
        default: begin
          start = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      op_ff <= 4'h0;
      addr_ff <= 20'h00000;
      data_ff <= 16'h0000;
      cmd_ff <= 8'h00;
      lockCnt_ff <= 3'h0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 16'h0000;
      rspError <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      reqReady <= (state_ff == ST_IDLE) && !reqValid;
      unique case (state_ff)
        ST_IDLE: if (reqValid && reqReady) begin
          reqReady <= 1'b0;
          op_ff <= reqOp;
          addr_ff <= reqAddr;
          data_ff <= reqData;
          cmd_ff <= opCode(reqOp);
          lockCnt_ff <= 3'h0;
          rspError <= 1'b0;
          if (reqOp == 4'h4 && bufOpen_ff) begin
            // Buffer still open within the gap: just load. R10
            state_ff <= ST_DATA;
          end else if (usesUnlock(reqOp)) begin
            state_ff <= ST_UNL1;
          end else if (reqOp == 4'h8) begin
            state_ff <= ST_DATA;
          end else begin
            state_ff <= ST_DONE;
          end
        end
        ST_UNL1: if (cyDone) state_ff <= ST_UNL2;
        ST_UNL2: if (cyDone) state_ff <= ST_CMD;
        ST_CMD: if (cyDone) begin
          if (op_ff == 4'h6 && cmd_ff == flash_host_pkg::CMD_LOCK_SETUP) begin
            state_ff <= ST_REPEAT;
          end else if (op_ff == 4'h4 || op_ff == 4'h5 || op_ff == 4'h1) begin
            state_ff <= ST_DATA;
          end else if (op_ff == 4'h3 || op_ff == 4'h2) begin
            // Sleep and clear finish by polling status. R7
            state_ff <= ST_POLL;
          end else if (op_ff == 4'h7) begin
            addr_ff <= flash_host_pkg::LOCK_ID_OFFSET;
            state_ff <= ST_DATA;
          end else begin
            state_ff <= ST_DONE;
          end
        end
        ST_REPEAT: if (cyDone) begin
          cmd_ff <= flash_host_pkg::UNLOCK_DATA2;
          state_ff <= ST_LOCK1;
        end
        ST_LOCK1: if (cyDone) state_ff <= ST_LOCK2;
        ST_LOCK2: if (cyDone) begin
          // Six writes in all; ready flag ends the lock. R17
          state_ff <= ST_POLL;
        end
        ST_DATA: if (cyDone) begin
          rspData <= cyRd;
          state_ff <= ST_DONE;
        end
        ST_POLL: if (cyDone) begin
          rspData <= cyRd;
          // Ready first, then the error bits. R23
          if (cyRd[flash_host_pkg::SR_READY]) begin
            rspError <= cyRd[flash_host_pkg::SR_PROG_ERR]
              | cyRd[flash_host_pkg::SR_ERASE_ERR];
            if (op_ff == 4'h6 && lockCnt_ff <
                3'(flash_host_pkg::LOCK_REPEATS)) begin
              // Lock is repeated once ready is set, before the lock bit is checked. R24
              lockCnt_ff <= lockCnt_ff + 3'h1;
              cmd_ff <= flash_host_pkg::CMD_LOCK_SETUP;
              state_ff <= ST_UNL1;
            end else begin
              if (op_ff == 4'h6) begin
                rspError <= ~cyRd[flash_host_pkg::SR_BOOT_LOCK];
              end
              state_ff <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          rspValid <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Buffer-write window: after 30 us without a load the device leaves
  // buffer mode, so the next load must re-issue the command prefix.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bufOpen_ff <= 1'b0;
      gap_ff <= 32'h0;
    end else if (state_ff == ST_DATA && op_ff == 4'h4 && cyDone) begin
      bufOpen_ff <= 1'b1;
      gap_ff <= 32'(LOAD_GAP) - 32'h2;
    end else if (state_ff == ST_UNL1 || op_ff != 4'h4) begin
      bufOpen_ff <= 1'b0;
    end else if (gap_ff != 32'h0) begin
      gap_ff <= gap_ff - 32'h1;
    end else begin
      bufOpen_ff <= 1'b0; // R12
    end
  end

  // ----------------------------------------------------------------
  // Protection and width pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_powerdown_pin <= 1'b0;
      wpLow <= 1'b1;
      elevated_high_level <= 1'b0;
      byteWide_n <= 1'b1;
    end else begin
      if (state_ff == ST_IDLE && reqValid && reqReady) begin
        if (reqOp == 4'h9) reset_powerdown_pin <= 1'b0; // R19
        if (reqOp == 4'ha) reset_powerdown_pin <= 1'b1; // R16
      end
      wpLow <= protLow; // R20
      elevated_high_level <= protElevated & ~protLow; // R21
      if (state_ff == ST_IDLE) byteWide_n <= wordMode;
    end
  end

  property p_lock_six;
    @(posedge clk) disable iff (sys_rst)
      (state_ff == ST_LOCK2 && cyDone) |=> state_ff == ST_POLL;
  endproperty
  a_lock_six: assert property (p_lock_six) else $error("lock bad"); // R17

  property p_ready_first;
    @(posedge clk) disable iff (sys_rst)
      $rose(rspError) |-> $past(cyRd[flash_host_pkg::SR_READY]);
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("err"); // R23

  property p_pd;
    @(posedge clk) disable iff (sys_rst)
      (state_ff == ST_IDLE && reqValid && reqReady && reqOp == 4'h9)
        |=> !reset_powerdown_pin;
  endproperty
  a_pd: assert property (p_pd) else $error("pd"); // R19
endmodule
`default_nettype wire

// ==== src/flash_host_pkg.sv ====
package flash_host_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SLEEP = 8'hc0;
  localparam logic [7:0] CMD_BUF_WRITE = 8'he0;
  localparam logic [7:0] CMD_BUF_READ = 8'h75;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h20;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
  localparam logic [19:0] UNLOCK_ADDR2 = 20'h002aa;
  localparam logic [19:0] LOCK_ID_OFFSET = 20'h00002;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int SR_READY = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_SLEEP = 2;
  localparam int SR_BOOT_LOCK = 1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NS = 120;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_GAP_US = 30;
  localparam int LOAD_GAP_CYC = LOAD_GAP_US * 1000 / CLK_PERIOD_NS;
  localparam int LOCK_REPEATS = 3;
  localparam int LOCK_RETRIES = 4;
  localparam int BUF_BYTES = 128;
  typedef enum logic [2:0] {
    OP_WRITE = 3'h0,
    OP_READ = 3'h1,
    OP_SEQ = 3'h2
  } op_t;
endpackage

// ==== test/flash_dev_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Behavioural flash device seen through its strobes
// ----------------------------------------------------------------
// The load window and lock busy time are shortened for simulation.
module flash_dev_model #(
  parameter int GAP_NS = 2000,
  parameter int LOCK_NS = 400,
  parameter logic [15:0] MFR_ID = 16'h005a // Arbitrary value.
) (
  input wire logic [19:0] addr,
  input wire logic [15:0] dqOut,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic byteWide_n,
  input wire logic powerPin,
  input wire logic wpLow,
  input wire logic wpHigh,
  input wire logic errSet,
  output logic [15:0] dqIn
);
  logic [15:0] bufMem [64];
  logic [1:0] mode = 2'h0;
  logic [1:0] step = 2'h0;
  logic wordLat = 1'b1;
  logic bufOn = 1'b0;
  logic lockSet = 1'b0;
  logic sleepOn = 1'b0;
  logic lockBit = 1'b0;
  logic progErr = 1'b0;
  logic ready = 1'b1;
  logic [19:0] aLat = 20'h00000;
  logic [15:0] rdLat = 16'h0000;
  logic [15:0] last = 16'h0000;
  time tFall = 0;
  time tRise = 0;
  wire wrAct = ~ce_n & ~we_n & oe_n;
  wire drv = ~ce_n & ~oe_n & powerPin;
  wire bootLk = ~wpHigh & (wpLow | lockBit);
  wire [7:0] stat = {ready, 2'b00, progErr, 1'b0, sleepOn, bootLk, 1'b0};
  // Released lines show the inverse of the last value, so stale data fails.
  assign dqIn = {(drv & byteWide_n) ? rdLat[15:8] : ~last[15:8],
    drv ? rdLat[7:0] : ~last[7:0]};
  always @(negedge drv) last = rdLat;
  always @(posedge errSet) progErr = 1'b1;
  always @(negedge powerPin) begin
    mode = 2'h0;
    step = 2'h0;
  end
  always @(posedge drv) begin
    case (mode)
      2'h1: rdLat = {8'h00, stat};
      2'h2: rdLat = bufMem[addr[5:0]];
      2'h3: rdLat = (addr[7:0] == 8'h02 && bootLk) ? MFR_ID : 16'h0000;
      default: rdLat = addr[15:0] ^ 16'h5a3c;
    endcase
  end
  always @(posedge wrAct) begin
    aLat = addr;
    tFall = $time;
    if (step == 2'h2) wordLat = byteWide_n;
  end
  always @(negedge wrAct) begin
    if (powerPin && bufOn && tFall - tRise <= GAP_NS) begin
      if (wordLat) bufMem[aLat[5:0]] = dqOut;
      else bufMem[aLat[5:0]][7:0] = dqOut[7:0];
      tRise = $time;
    end else if (powerPin) begin
      bufOn = 1'b0;
      command(dqOut[7:0]);
    end
  end
  task automatic command(input logic [7:0] d);
    if (step != 2'h2) begin
      step = (d == (step == 2'h0 ? 8'haa : 8'h55)) ? step + 2'h1 : 2'h0;
    end else begin
      step = 2'h0;
      if (!progErr || d == 8'h50 || d == 8'h70 || d == 8'hff) begin
        case (d)
          8'h70: mode = 2'h1;
          8'h50: progErr = 1'b0;
          8'hff: begin
            mode = 2'h0;
            sleepOn = 1'b0;
          end
          8'hc0: begin
            mode = 2'h1;
            sleepOn = 1'b1;
          end
          8'he0: begin
            bufOn = 1'b1;
            tRise = $time;
          end
          8'h75: mode = 2'h2;
          8'h90: mode = 2'h3;
          8'h20: if (lockSet) begin
            lockBit = 1'b1;
            ready = 1'b0;
            mode = 2'h1;
            fork
              #(LOCK_NS) ready = 1'b1;
            join_none
          end
          default: ;
        endcase
        lockSet = (d == 8'h60);
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Wiring, queue of expected answers and checking
  // ----------------------------------------------------------------
  localparam logic [15:0] MFR_ID = 16'h005a; // Arbitrary value.
  typedef struct {
    logic [15:0] d;
    logic [15:0] m;
    logic [1:0] e;
  } exp_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  logic [3:0] reqOp = 4'h0;
  logic [19:0] reqAddr = 20'h00000;
  logic [15:0] reqData = 16'h0000;
  logic wordMode = 1'b1;
  logic protLow = 1'b0;
  logic protElevated = 1'b0;
  logic errSet = 1'b0;
  logic reqReady, rspValid, rspError, dqOe_n, ce_n, we_n, oe_n;
  logic byteWide_n, powerPin, wpLow, wpHigh;
  logic [15:0] rspData, dqOut, dqIn;
  logic [19:0] addr;
  logic [15:0] bufExp [64];
  exp_t q[$];
  exp_t e;
  int nMismatch = 0;
  int compares = 0;
  int nRsp = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  flash_host_ctrl #(.LOAD_GAP(200)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .wordMode(wordMode), .protLow(protLow),
    .protElevated(protElevated), .dqIn(dqIn), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
    .addr(addr), .dqOut(dqOut), .dqOe_n(dqOe_n), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .byteWide_n(byteWide_n), .reset_powerdown_pin(powerPin),
    .wpLow(wpLow), .elevated_high_level(wpHigh));
  flash_dev_model #(.MFR_ID(MFR_ID)) u_dev (.addr(addr), .dqOut(dqOut),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .byteWide_n(byteWide_n),
    .powerPin(powerPin), .wpLow(wpLow), .wpHigh(wpHigh), .errSet(errSet),
    .dqIn(dqIn));
  task automatic printVerdict();
    if (nMismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmpData(input logic [15:0] got, ex, m);
    compares++;
    if ((got & m) !== (ex & m)) begin
      nMismatch++;
      $display("ERROR %0t data %h expected %h", $time, got, ex);
    end
  endtask
  task automatic cmpErr(input logic got, ex);
    compares++;
    if (got !== ex) begin
      nMismatch++;
      $display("ERROR %0t error flag %b expected %b", $time, got, ex);
    end
  endtask
  // One request: held until taken, then wait for its answer.
  task automatic run(input logic [3:0] op, input logic [15:0] ed = 16'h0,
      input logic [15:0] m = 16'h0, input logic [19:0] a = 20'h0,
      input logic [15:0] d = 16'h0, input logic [1:0] ee = 2'h0);
    int k;
    k = nRsp;
    q.push_back('{ed, m, ee});
    while (reqReady !== 1'b1) @(negedge clk);
    reqOp = op;
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    while (nRsp == k) @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (rspValid === 1'b1) begin
      if (q.size() == 0) begin
        nMismatch++;
        $display("ERROR %0t unexpected answer", $time);
      end else begin
        e = q.pop_front();
        if (e.m != 16'h0) cmpData(rspData, e.d, e.m);
        if (e.e[1]) cmpErr(rspError, e.e[0]);
      end
      nRsp++;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      nMismatch++;
      $display("ERROR %0t run did not finish", $time);
      printVerdict();
    end
  end
  initial begin
    int idx [8];
    logic [15:0] v;
    void'($urandom(92));
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    run(4'ha);
    run(4'h8, 16'h0123 ^ 16'h5a3c, 16'hffff, 20'h00123);
    run(4'h1, 16'h0080, 16'hffff);
    run(4'h8, 16'h0080, 16'hffff, 20'h00040);
    run(4'h3);
    run(4'h1, 16'h0084, 16'hffff);
    run(4'h0);
    run(4'h1, 16'h0080, 16'hffff);
    errSet = 1'b1;
    @(negedge clk);
    errSet = 1'b0;
    run(4'h1, 16'h0090, 16'hffff);
    run(4'h3, 16'h0090, 16'hffff, 20'h0, 16'h0, 2'b11);
    run(4'h1, 16'h0090, 16'hffff);
    run(4'h2, 16'h0080, 16'hffff, 20'h0, 16'h0, 2'b10);
    run(4'h1, 16'h0080, 16'hffff);
    wordMode = 1'b0;
    run(4'h1, 16'h0080, 16'h00ff);
    wordMode = 1'b1;
    run(4'h0);
    for (int i = 0; i < 8; i++) begin
      idx[i] = i * 8 + $urandom_range(7);
      v = 16'($urandom);
      bufExp[idx[i]] = v;
      // A pause longer than the load window forces a fresh prefix.
      if (i == 5) repeat (300) @(negedge clk);
      run(4'h4, 16'h0, 16'h0, 20'(idx[i]), v);
    end
    repeat (300) @(negedge clk);
    for (int i = 7; i >= 0; i--) begin
      run(4'h5, bufExp[idx[i]], 16'hffff, 20'(idx[i]));
    end
    run(4'h7, 16'h0000, 16'hffff);
    protLow = 1'b1;
    run(4'h7, MFR_ID, 16'hffff);
    protLow = 1'b0;
    run(4'h6, 16'h0, 16'h0, 20'h0, 16'h0, 2'b10);
    run(4'h7, MFR_ID, 16'hffff);
    run(4'h1, 16'h0082, 16'hffff);
    protElevated = 1'b1;
    run(4'h7, 16'h0000, 16'hffff);
    protElevated = 1'b0;
    // A command written while powered down must not take effect.
    run(4'h9);
    run(4'h1);
    run(4'ha);
    run(4'h8, 16'h0077 ^ 16'h5a3c, 16'hffff, 20'h00077);
    printVerdict();
  end
endmodule
`default_nettype wire
